/* File: dv/aic_host_dma.sv */
/*
 Host side of the DMA link: acknowledges requests and gives one read
 strobe per 16-bit word. Assumes the card counts a word at the edge
 after the strobe ends and that all strobes are synchronous to hclk.
*/
`timescale 1ns/1ns
module aic_host_dma (
   input  wire logic        hclk,     // Bus clock
   input  wire logic        hresetn,  // Reset, active low
   input  wire logic        dmareq,   // Request from card
   input  wire logic [15:0] dma_data, // Word offered by card
   input  wire logic [3:0]  gap,      // Extra idle cycles per word
   output logic             dmack_n,  // Acknowledge, active low
   output logic             iord_n,   // Read strobe, active low
   output int               words,    // Words taken so far
   output logic [15:0]      last_w    // Last word taken
);
   logic [3:0] cnt;   // Cycles in present strobe phase
   logic       str_d; // Strobe as seen one edge ago
   // Strobe low two cycles, high two plus gap; gap lets it run slow
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {dmack_n, iord_n, str_d} <= 3'h7;
         cnt <= 4'h0;
         words <= 0;
         last_w <= 16'h0;
      end else begin
         str_d <= iord_n;
         dmack_n <= !(dmareq || !iord_n);
         if (!str_d && iord_n) begin
            words <= words + 1;
            last_w <= dma_data;
         end
         if (!iord_n && cnt != 4'h0) begin
            iord_n <= 1'b1;
            cnt <= 4'h0;
         end else if (iord_n && dmareq && cnt >= gap + 4'h1) begin
            iord_n <= 1'b0;
            cnt <= 4'h0;
         end else if (cnt != 4'hF) begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule

/* File: dv/test_ata_idle_and_dma_read_cmds.sv */
/*
 Bench for the task-file block: AHB-Lite register tasks, a media
 stand-in and a host DMA model. Assumes one 10 MHz clock and a
 four-word sector so that long transfers stay short.
*/
`timescale 1ns/1ns
module test_ata_idle_and_dma_read_cmds import aic_pkg::*;;
   localparam int W = 4; // Words per sector in this run
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0;
   logic        hwrite = 1'b0, media_valid = 1'b0, media_error = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
   logic [15:0] media_data = 16'h0, dma_data, last_w;
   logic [27:0] media_addr, a0;
   logic [7:0]  mbase;
   logic [3:0]  hgap = 4'h0;
   logic        hready, hresp, intrq, dmareq, dmack_n, iord_n;
   logic        media_req, media_lba, iq_d;
   logic [7:0]  ops [5] = '{OP_IDLE_B, OP_IDLE_A, OP_IDLEI_A,
                            OP_IDLEI_B, OP_IDLE_B};
   int failures = 0, compares = 0, words, mleft = 0, msec = 0;
   int err_at = -1, nint = 0;

   always #50 hclk = ~hclk;

   aic_taskfile #(.WORDS(W), .APD_TICK(10), .IO_MODE(3'h3),
      .MEM_MODE(3'h2)) u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready, .hreadyout(hready), .hrdata,
      .hresp, .intrq, .dmareq, .dmack_n, .iord_n, .dma_data,
      .media_req, .media_addr, .media_lba, .media_valid, .media_data,
      .media_error);
   aic_host_dma u_host (.hclk, .hresetn, .dmareq, .dma_data,
      .gap(hgap), .dmack_n, .iord_n, .words, .last_w);

   // Media stand-in; data toggles when not valid so stale words show
   always @(posedge hclk) begin
      media_valid <= 1'b0;
      media_error <= 1'b0;
      media_data <= ~media_data;
      iq_d <= intrq;
      if (intrq && !iq_d) nint <= nint + 1;
      if (media_req) begin
         if (msec == 0) a0 <= media_addr;
         msec <= msec + 1;
         mleft <= W;
         mbase <= media_addr[7:0];
      end else if (mleft > 0 && msec == err_at) begin
         media_error <= 1'b1;
         mleft <= 0;
      end else if (mleft > 0) begin
         media_valid <= 1'b1;
         media_data <= {mbase, 8'(W - mleft)};
         mleft <= mleft - 1;
      end
   end

   task automatic chk(input string n, input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   // One single word transfer; read data lands in v
   task automatic bus(input logic wr, input logic [3:0] idx,
                      input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {26'h0, idx, 2'h0};
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      v = hrdata;
      chk("hresp", hresp, 1'b0);
   endtask
   // Wait for the interrupt, then read status, which clears it
   task automatic wait_int(input int n);
      for (int i = 0; i < n && intrq !== 1'b1; i++) @(posedge hclk);
      chk("intrq", intrq, 1);
      bus(0, IDX_CMD, 0);
   endtask
   // Counters are owned by the media stand-in and the host model; work on differences
   task automatic dma(input logic [7:0] cnt, input int ea, nsec);
      int w0, m0, n0;
      w0 = words;
      m0 = msec;
      n0 = nint;
      err_at = (ea < 0) ? -1 : m0 + ea;
      bus(1, IDX_SCNT, cnt);
      bus(1, IDX_CMD, OP_RDDMA);
      wait_int(20000);
      chk("dmareq", dmareq, 0);
      chk("sectors", msec - m0, nsec);
      chk("irqs", nint - n0, 1);
      if (ea < 0) chk("words", words - w0, nsec * W);
   endtask
   task stop_test;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (80000) @(posedge hclk);
      failures++;
      stop_test;
   end

   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      bus(1, IDX_IDW, 32'hFFFF);
      bus(0, IDX_IDW, 0);
      chk("ident", v, 32'h13);
      bus(0, 4'hF, 0);
      chk("unmapped", v, 32'h0);
      foreach (ops[i]) begin
         bus(1, IDX_SCNT, (i % 2 == 0) ? 32'h2 : 32'h0);
         bus(1, IDX_CMD, ops[i]);
         wait_int(50);
         chk("intrq clr", intrq, 0);
         bus(0, IDX_CFG, 0);
         chk("idle", v[CFG_IDLE], 1);
         chk("apd", v[CFG_APD], i % 4 == 0);
         chk("no stby", v[CFG_STBY], 0);
      end
      repeat (40) @(posedge hclk);
      bus(0, IDX_CFG, 0);
      chk("standby", v[CFG_STBY], 1);
      bus(1, IDX_SCNT, 32'h11);
      bus(1, IDX_CDH, 32'hA3);
      bus(1, IDX_CMD, OP_INIT);
      wait_int(50);
      bus(0, IDX_GEOM, 0);
      chk("geom", v, 32'h311);
      bus(1, IDX_CYLH, 32'h12);
      bus(1, IDX_CYLL, 32'h34);
      bus(1, IDX_SNUM, 32'hFE);
      bus(1, IDX_CDH, 32'hE5);
      dma(8'h3, -1, 3);
      chk("lba", media_lba, 1);
      chk("start", a0, 28'h51234FE);
      chk("lastw", last_w, {8'h0, 8'(W - 1)});
      bus(0, IDX_SNUM, 0);
      chk("snum", v[7:0], 8'h00);
      bus(0, IDX_CYLL, 0);
      chk("cyll", v[7:0], 8'h35);
      bus(1, IDX_CMD, OP_RDBUF);
      for (int i = 0; i < 50 && v[ST_DRQ] !== 1'b1; i++) bus(0, IDX_CMD, 0);
      chk("drq", v[ST_DRQ], 1);
      for (int i = 0; i < W; i++) begin
         bus(0, IDX_DATA, 0);
         chk("buf", v[15:0], {8'h0, 8'(i)});
      end
      bus(0, IDX_CMD, 0);
      chk("drq end", v[ST_DRQ], 0);
      // Cylinder/head/sector stepping: last sector and last head wrap
      bus(1, IDX_CYLL, 32'h34);
      bus(1, IDX_SNUM, 32'h11);
      bus(1, IDX_CDH, 32'hA3);
      dma(8'h2, -1, 2);
      chk("chs", media_lba, 0);
      bus(0, IDX_CDH, 0);
      chk("chs head", v[7:0], 8'hA0);
      bus(0, IDX_SNUM, 0);
      chk("chs snum", v[7:0], 8'h01);
      bus(0, IDX_CYLL, 0);
      chk("chs cyl", v[7:0], 8'h35);
      hgap <= 4'h3;
      dma(8'h0, -1, 256);
      bus(1, IDX_SNUM, 32'h10);
      dma(8'h3, 2, 2);
      chk("err st", v[ST_ERR], 1);
      bus(0, IDX_FEAT, 0);
      chk("unc", v[ER_UNC], 1);
      bus(0, IDX_SNUM, 0);
      chk("err snum", v[7:0], 8'h11);
      bus(1, IDX_CFG, 32'h1);
      dma(8'h1, -1, 0);
      chk("abrt st", v[ST_ERR], 1);
      bus(0, IDX_FEAT, 0);
      chk("abrt", v[ER_ABRT], 1);
      // An opcode this block does not handle is aborted
      bus(1, IDX_CFG, 32'h0);
      bus(1, IDX_CMD, 32'h20);
      wait_int(50);
      chk("unk op", v[ST_ERR], 1);
      stop_test;
   end
endmodule

/* File: hdl/aic_pkg.sv */
/*
 Constants for the task-file command block: register indices, opcodes,
 status and error bit positions, identify-word fields and timing.
 Assumes a single 10 MHz clock shared with the bus.
*/
package aic_pkg;
   // Register indices (byte address is four times the index)
   localparam logic [3:0] IDX_DATA = 4'h0; // Sector buffer data port
   localparam logic [3:0] IDX_FEAT = 4'h1; // Feature write, error read
   localparam logic [3:0] IDX_SCNT = 4'h2; // Sector count
   localparam logic [3:0] IDX_SNUM = 4'h3; // Sector number
   localparam logic [3:0] IDX_CYLL = 4'h4; // Cylinder low
   localparam logic [3:0] IDX_CYLH = 4'h5; // Cylinder high
   localparam logic [3:0] IDX_CDH  = 4'h6; // Card/drive/head select
   localparam logic [3:0] IDX_CMD  = 4'h7; // Command write, status read
   localparam logic [3:0] IDX_IDW  = 4'h8; // Advanced timing identify word
   localparam logic [3:0] IDX_CFG  = 4'h9; // Config and power state
   localparam logic [3:0] IDX_GEOM = 4'hA; // Translation geometry
   // Opcodes
   localparam logic [7:0] OP_IDLE_A  = 8'h97;
   localparam logic [7:0] OP_IDLE_B  = 8'hE3;
   localparam logic [7:0] OP_IDLEI_A = 8'h95;
   localparam logic [7:0] OP_IDLEI_B = 8'hE1;
   localparam logic [7:0] OP_INIT    = 8'h91;
   localparam logic [7:0] OP_RDBUF   = 8'hE4;
   localparam logic [7:0] OP_RDDMA   = 8'hC8;
   // Bit positions
   localparam int ST_BSY = 7, ST_DRDY = 6, ST_DSC = 4, ST_DRQ = 3;
   localparam int ST_ERR = 0, ER_UNC = 6, ER_ABRT = 2;
   localparam int CDH_LBA = 6, CFG_8BIT = 0;
   localparam int CFG_IDLE = 8, CFG_STBY = 9, CFG_APD = 10;
   // Identify word fields and reset values
   localparam logic [2:0] IO_MODE_255NS  = 3'h0; // Slowest I/O cycle
   localparam logic [2:0] MEM_MODE_250NS = 3'h0; // Slowest memory cycle
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_HEAD = 4'h0;
   // Power-down timer base
   localparam int APD_TICK_MS = 5;
   localparam int CLK_KHZ     = 10000;
   localparam int APD_TICK_CYC = APD_TICK_MS * CLK_KHZ;
endpackage

/* File: hdl/aic_taskfile.sv */
/*
 Task-file command interpreter: idle, idle immediate, geometry setup,
 buffer read over the bus and DMA read with its request/acknowledge
 handshake. Assumes an AHB-Lite master as the only bus master, a media
 engine that streams one sector per request, and DMA strobes that are
 already synchronous to hclk.
*/
`timescale 1ns/1ns
// Contract
// R1: Identify bits 2:0 give I/O cycle mode
// R2: Identify bits 5:3 give memory cycle mode
// R3: Identify bits 15:6 reserved, read zero
// R4: Idle: busy, idle, interrupt, arm timer
// R5: Idle with zero count disables power-down
// R6: Idle immediate: busy, idle, interrupt only
// R7: Geometry command loads sectors and heads
// R8: Geometry uses only count and head register
// R9: Buffer read returns present buffer contents
// R10: DMA read 1..256 sectors, zero means 256
// R11: DMA starts at addressed sector, LBA layout
// R12: DMA: busy, load buffer, then DRQ
// R13: DMAREQ held while data is ready
// R14: Host acks and strobes once per word
// R15: Host moves 512 bytes per sector
// R16: DMA interrupts only at end or error
// R17: Success leaves last sector address
// R18: Error stops at failing sector address
// R19: Eight-bit mode aborts DMA read
// R20: Sector protocol: busy, fill, DRQ, interrupt
// R21: Identify timing word is read-only
module aic_taskfile import aic_pkg::*; #(
   parameter int           WORDS        = 256,          // Words per sector
   parameter int           APD_TICK     = APD_TICK_CYC, // Cycles per tick
   parameter logic [2:0]   IO_MODE      = IO_MODE_255NS,
   parameter logic [2:0]   MEM_MODE     = MEM_MODE_250NS
) (
   input  wire logic        hclk,        // Bus clock
   input  wire logic        hresetn,     // Async reset, active low
   input  wire logic        hsel,        // Slave select
   input  wire logic [31:0] haddr,       // Byte address
   input  wire logic [1:0]  htrans,      // Transfer type
   input  wire logic        hwrite,      // Write when high
   input  wire logic [2:0]  hsize,       // Transfer size
   input  wire logic [31:0] hwdata,      // Write data
   input  wire logic        hready,      // Bus ready
   output logic             hreadyout,   // Always ready
   output logic [31:0]      hrdata,      // Read data
   output logic             hresp,       // Always OKAY
   output logic             intrq,       // Host interrupt, level
   output logic             dmareq,      // DMA request
   input  wire logic        dmack_n,     // DMA acknowledge, low
   input  wire logic        iord_n,      // Read strobe, low
   output logic [15:0]      dma_data,    // DMA word to host
   output logic             media_req,   // Sector fetch pulse
   output logic [27:0]      media_addr,  // Head, cyl high, cyl low, sector
   output logic             media_lba,   // Address is LBA
   input  wire logic        media_valid, // Word from media
   input  wire logic [15:0] media_data,  // Media word
   input  wire logic        media_error  // Unrecoverable media error
);
   localparam int PW = $clog2(WORDS);
   localparam int TW = $clog2(APD_TICK + 1);
   localparam logic [PW-1:0] LAST_W = PW'(WORDS - 1);
   localparam logic [TW-1:0] TICK_LAST = TW'(APD_TICK - 1);

   typedef enum logic [2:0] {
      S_RDY,   // Waiting for a command
      S_BSY,   // Brief busy step
      S_FETCH, // Loading a sector from media
      S_DMA,   // Buffer offered over DMA
      S_PIO    // Buffer offered over the data register
   } aic_state_e;

   typedef struct packed {
      aic_state_e    state;     // Control state
      logic          to_pio;    // Busy step leads to PIO
      logic [7:0]    feat;      // Feature parameter
      logic [7:0]    scnt;      // Sector count
      logic [7:0]    snum;      // Sector number
      logic [7:0]    cyll;      // Cylinder low
      logic [7:0]    cylh;      // Cylinder high
      logic [7:0]    cdh;       // Card/drive/head
      logic          abrt;      // Aborted command
      logic          unc;       // Unrecoverable error
      logic          intrq;     // Pending interrupt
      logic          eight;     // Eight-bit transfers on
      logic [7:0]    spt;       // Sectors per track
      logic [3:0]    mhead;     // Highest head number
      logic          idle;      // Idle mode entered
      logic          stby;      // Powered down by timer
      logic          apd_en;    // Auto power-down armed
      logic [7:0]    apd_load;  // Timer reload in ticks
      logic [7:0]    apd_left;  // Ticks remaining
      logic [TW-1:0] tick;      // Cycles within a tick
      logic [8:0]    remain;    // Sectors still to read
      logic [PW-1:0] wptr;      // Buffer fill pointer
      logic [PW-1:0] rptr;      // Buffer drain pointer
      logic          iord_q;    // Strobe last cycle
      logic          dma_cmd;   // Current command is DMA read
      logic          wr_pend;   // Write data phase pending
      logic [3:0]    wr_idx;    // Index of pending write
      logic [31:0]   rdata;     // Registered read data
      logic          mreq;      // Media request pulse
      logic [15:0]   ddata;     // DMA data word
   } aic_s;

   aic_s        cur;       // Registered state
   aic_s        next_cur;  // Next state
   logic [15:0] buf_mem [WORDS]; // Sector buffer, no reset needed
   logic [15:0] buf_rd;    // Word at the drain pointer
   logic        take;      // Address phase accepted
   logic [3:0]  a_idx;     // Index of address phase
   logic        go;        // Command accepted this cycle
   logic [7:0]  op;        // Command opcode
   logic        word_done; // Host finished a DMA word
   logic [15:0] idword;    // Advanced timing identify word
   logic [7:0]  status;    // Status byte
   logic [7:0]  errbyte;   // Error byte

   assign take   = hsel && htrans[1] && hready;
   assign a_idx  = haddr[5:2];
   assign op     = hwdata[7:0];
   assign go     = cur.wr_pend && (cur.wr_idx == IDX_CMD)
                   && (cur.state == S_RDY);
   assign buf_rd = buf_mem[cur.rptr];
   // Count the word when the strobe ends, the host having latched it
   assign word_done = (cur.state == S_DMA) && !dmack_n && iord_n
                      && !cur.iord_q;                   // see R14
   // Fixed by the card; upper bits reserved as zero
   assign idword = {10'h000, MEM_MODE, IO_MODE};        // see R1 R2 R3 R21

   // Status and error bytes as seen by the host
   always_comb begin
      status = 8'h00;
      status[ST_BSY]  = (cur.state == S_BSY) || (cur.state == S_FETCH);
      status[ST_DRDY] = !status[ST_BSY];
      status[ST_DSC]  = 1'b1;
      status[ST_DRQ]  = (cur.state == S_DMA) || (cur.state == S_PIO);
      status[ST_ERR]  = cur.abrt || cur.unc;
      errbyte = 8'h00;
      errbyte[ER_UNC]  = cur.unc;
      errbyte[ER_ABRT] = cur.abrt;
   end

   // All next-state logic of the block except the sector buffer fill
   always_comb begin
      next_cur = cur;
      next_cur.mreq   = 1'b0;
      next_cur.iord_q = iord_n;
      next_cur.ddata  = buf_rd;
      next_cur.wr_pend = take && hwrite;
      if (take && hwrite) begin
         next_cur.wr_idx = a_idx;
      end
      // Read side effects happen in the address phase
      if (take && !hwrite) begin
         next_cur.rdata = 32'h0000_0000;
         case (a_idx)
            IDX_DATA: begin
               if (cur.state == S_PIO) begin
                  next_cur.rdata = {16'h0000, buf_rd};  // see R9
                  next_cur.rptr  = cur.rptr + 1'b1;
                  if (cur.rptr == LAST_W) begin
                     next_cur.state = S_RDY;            // Last word ends it
                  end
               end
            end
            IDX_FEAT: next_cur.rdata = {24'h000000, errbyte};
            IDX_SCNT: next_cur.rdata = {24'h000000, cur.scnt};
            IDX_SNUM: next_cur.rdata = {24'h000000, cur.snum};
            IDX_CYLL: next_cur.rdata = {24'h000000, cur.cyll};
            IDX_CYLH: next_cur.rdata = {24'h000000, cur.cylh};
            IDX_CDH:  next_cur.rdata = {24'h000000, cur.cdh};
            IDX_CMD: begin
               next_cur.rdata = {24'h000000, status};
               next_cur.intrq = 1'b0;   // Status read acknowledges
            end
            IDX_IDW:  next_cur.rdata = {16'h0000, idword}; // see R21
            IDX_CFG: begin
               next_cur.rdata[CFG_8BIT] = cur.eight;
               next_cur.rdata[CFG_IDLE] = cur.idle;
               next_cur.rdata[CFG_STBY] = cur.stby;
               next_cur.rdata[CFG_APD]  = cur.apd_en;
            end
            IDX_GEOM: next_cur.rdata = {20'h00000, cur.mhead, cur.spt};
            default:  next_cur.rdata = 32'h0000_0000; // Unmapped
         endcase
      end
      // Register writes; task file is locked while busy
      if (cur.wr_pend && (cur.state == S_RDY)) begin
         case (cur.wr_idx)
            IDX_FEAT: next_cur.feat = op;
            IDX_SCNT: next_cur.scnt = op;
            IDX_SNUM: next_cur.snum = op;
            IDX_CYLL: next_cur.cyll = op;
            IDX_CYLH: next_cur.cylh = op;
            IDX_CDH:  next_cur.cdh  = op;
            IDX_CFG:  next_cur.eight = hwdata[CFG_8BIT];
            default: begin
            end
         endcase
      end
      // Power-down timer runs only while idle and armed
      if (cur.state == S_RDY && cur.idle && cur.apd_en && !cur.stby) begin
         if (cur.tick == TICK_LAST) begin
            next_cur.tick = '0;
            if (cur.apd_left <= 8'h01) begin
               next_cur.stby = 1'b1;
            end else begin
               next_cur.apd_left = cur.apd_left - 8'h01;
            end
         end else begin
            next_cur.tick = cur.tick + 1'b1;
         end
      end
      // Command decode
      if (go) begin
         next_cur.abrt = 1'b0;
         next_cur.unc  = 1'b0;
         next_cur.stby = 1'b0;
         next_cur.tick = '0;
         next_cur.apd_left = cur.apd_load;
         next_cur.dma_cmd = 1'b0;
         next_cur.to_pio  = 1'b0;
         next_cur.state   = S_BSY;
         case (op)
            OP_IDLE_A, OP_IDLE_B: begin
               next_cur.idle = 1'b1;                    // see R4
               next_cur.apd_en = (cur.scnt != 8'h00);   // see R4 R5
               next_cur.apd_load = cur.scnt;
               next_cur.apd_left = cur.scnt;
            end
            OP_IDLEI_A, OP_IDLEI_B: begin
               next_cur.idle = 1'b1;                    // see R6
            end
            OP_INIT: begin
               next_cur.spt   = cur.scnt;               // see R7 R8
               next_cur.mhead = cur.cdh[3:0];
            end
            OP_RDBUF: begin
               next_cur.to_pio = 1'b1;                  // see R9 R20
            end
            OP_RDDMA: begin
               if (cur.eight) begin
                  next_cur.abrt = 1'b1;                 // see R19
               end else begin
                  next_cur.dma_cmd = 1'b1;
                  next_cur.remain  = {cur.scnt == 8'h00, cur.scnt}; // see R10
                  next_cur.state = S_FETCH;             // see R12
                  next_cur.wptr  = '0;
                  next_cur.mreq  = 1'b1;                // see R11
               end
            end
            default: next_cur.abrt = 1'b1; // Not handled here
         endcase
      end
      // Sequencing
      case (cur.state)
         S_BSY: begin
            next_cur.intrq = 1'b1;                      // see R4 R6 R20
            next_cur.rptr  = '0;
            next_cur.state = cur.to_pio ? S_PIO : S_RDY;
         end
         S_FETCH: begin
            if (media_error) begin
               next_cur.unc   = 1'b1;                   // see R18
               next_cur.intrq = 1'b1;                   // see R16
               next_cur.state = S_RDY;
            end else if (media_valid) begin
               next_cur.wptr = cur.wptr + 1'b1;
               if (cur.wptr == LAST_W) begin
                  next_cur.rptr  = '0;
                  next_cur.state = S_DMA;               // see R12
               end
            end
         end
         S_DMA: begin
            if (word_done) begin
               next_cur.rptr = cur.rptr + 1'b1;
               if (cur.rptr == LAST_W) begin
                  if (cur.remain == 9'h001) begin
                     // Address left on the last sector read
                     next_cur.intrq = 1'b1;             // see R16 R17
                     next_cur.state = S_RDY;
                  end else begin
                     // Step to the next sector, LBA or CHS order
                     next_cur.remain = cur.remain - 9'h001;
                     next_cur.state  = S_FETCH;
                     next_cur.wptr   = '0;
                     next_cur.mreq   = 1'b1;
                     if (cur.cdh[CDH_LBA]) begin
                        {next_cur.cdh[3:0], next_cur.cylh, next_cur.cyll,
                         next_cur.snum} = {cur.cdh[3:0], cur.cylh,
                         cur.cyll, cur.snum} + 28'h0000001; // see R11
                     end else if (cur.snum >= cur.spt) begin
                        next_cur.snum = 8'h01;
                        if (cur.cdh[3:0] >= cur.mhead) begin
                           next_cur.cdh[3:0] = RST_HEAD;
                           {next_cur.cylh, next_cur.cyll} =
                              {cur.cylh, cur.cyll} + 16'h0001;
                        end else begin
                           next_cur.cdh[3:0] = cur.cdh[3:0] + 4'h1;
                        end
                     end else begin
                        next_cur.snum = cur.snum + 8'h01;
                     end
                  end
               end
            end
         end
         default: begin
         end
      endcase
   end

   // Sector buffer fill from the media stream
   always_ff @(posedge hclk) begin
      if (cur.state == S_FETCH && media_valid && !media_error) begin
         buf_mem[cur.wptr] <= media_data;
      end
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cur <= '{state: S_RDY, feat: RST_BYTE, scnt: RST_BYTE,
                  snum: RST_BYTE, cyll: RST_BYTE, cylh: RST_BYTE,
                  cdh: RST_BYTE, spt: RST_BYTE, mhead: RST_HEAD,
                  apd_load: RST_BYTE, apd_left: RST_BYTE,
                  iord_q: 1'b1, default: '0};
      end else begin
         cur <= next_cur;
      end
   end

   assign hreadyout  = 1'b1;
   assign hresp      = 1'b0;
   assign hrdata     = cur.rdata;
   assign intrq      = cur.intrq;
   assign dmareq     = (cur.state == S_DMA);                // see R13
   assign dma_data   = cur.ddata;
   assign media_req  = cur.mreq;
   assign media_addr = {cur.cdh[3:0], cur.cylh, cur.cyll, cur.snum};
   assign media_lba  = cur.cdh[CDH_LBA];

   // Checks on the block's own state and outputs
   default clocking aic_cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_busy_then_int;
      status[ST_BSY] ##1 (!status[ST_BSY] && intrq);
   endsequence

   a_idle_seq: assert property ( // see R4 R6
      go && (op == OP_IDLE_A || op == OP_IDLE_B || op == OP_IDLEI_A
      || op == OP_IDLEI_B) |=> s_busy_then_int ##0 cur.idle)
      else $error("idle command sequence wrong");
   a_apd_off: assert property ( // see R5
      go && (op == OP_IDLE_A || op == OP_IDLE_B) && cur.scnt == 8'h00
      |=> !cur.apd_en) else $error("power-down not disabled");
   a_geom_load: assert property (go && op == OP_INIT |=> // see R7 R8
      cur.spt == $past(cur.scnt) && cur.mhead == $past(cur.cdh[3:0]))
      else $error("geometry not loaded");
   a_abort_8bit: assert property ( // see R19
      go && op == OP_RDDMA && cur.eight |=> cur.abrt ##1 (intrq && !dmareq))
      else $error("8-bit DMA not aborted");
   a_req_state: assert property (dmareq |-> status[ST_DRQ] // see R13
      && !status[ST_BSY]) else $error("DMA request without data");
   // Request must stay up until the sector's last word is taken
   a_req_hold: assert property ( // see R13
      dmareq && !(word_done && cur.rptr == LAST_W) |=> dmareq)
      else $error("DMA request dropped early");
   a_dma_int: assert property (cur.dma_cmd && $rose(intrq) |-> // see R16
      cur.state == S_RDY && (cur.remain == 9'h001 || cur.unc))
      else $error("DMA interrupt mid transfer");
   a_err_stop: assert property ( // see R18
      cur.state == S_FETCH && media_error |=>
      !dmareq && cur.unc && media_addr == $past(media_addr))
      else $error("error did not stop read");
   a_pio_drq: assert property ( // see R9 R20
      cur.state == S_BSY && cur.to_pio |=>
      status[ST_DRQ] && !status[ST_BSY] && intrq)
      else $error("buffer read not offered");
   a_count_zero: assert property ( // see R10
      go && op == OP_RDDMA && !cur.eight && cur.scnt == 8'h00
      |=> cur.remain == 9'h100) else $error("zero count not 256");
   a_ident_word: assert property ( // see R1 R2 R3
      take && !hwrite && a_idx == IDX_IDW
      |=> hrdata == {26'h0000000, MEM_MODE, IO_MODE})
      else $error("identify word wrong");
endmodule
